// ### verilog/jog_motion_regs.svh
`ifndef JOG_MOTION_REGS_SVH
`define JOG_MOTION_REGS_SVH

// register offsets on the setup port
`define ADDR_INTERLOCK_SETUP  4'h0
`define ADDR_FEED_SETUP       4'h1
`define ADDR_INPOS_WIDTH      4'h2
`define ADDR_MACHINE_SETUP    4'h3
`define ADDR_DIAG_STATUS      4'h4
`define ADDR_MOVE_STATUS      4'h5

// interlock setup word fields
`define GLOBAL_LOCK_DISABLE_BIT 0
`define AXIS_LOCK_DISABLE_BIT   2
`define DIR_LOCK_DISABLE_BIT    3

// manual feed setup word fields
`define PER_REV_FEED_SEL_BIT 3

// machine setup word fields
`define INDEX_AXIS_MSB        1
`define INDEX_AXIS_LSB        0
`define INDEX_AXIS_ENABLE_BIT 2
`define TURNING_VARIANT_BIT   3

// reset values
`define RESET_INTERLOCK_SETUP 16'h0000
`define RESET_FEED_SETUP      16'h0000
`define RESET_INPOS_WIDTH     16'h0014
`define RESET_MACHINE_SETUP   16'h0000

// mode select codes, bit 2 down to bit 0
`define MODE_JOG    3'h5
`define MODE_HANDLE 3'h4

// active-low rate word patterns and the decoded full-scale value
`define RATE_ALL_ONES   16'hffff
`define RATE_ALL_ZEROS  16'h0000
`define RATE_FULL_SCALE 16'h2710

// turning-variant direction lock byte positions
`define TURN_POS_LOCK1 2
`define TURN_NEG_LOCK1 3
`define TURN_POS_LOCK2 4
`define TURN_NEG_LOCK2 5

// servo amplifier indicator when activated
`define SERVO_READY_CODE 4'h0

// diagnostic status word bits
`define DIAG_INPOS_BIT     0
`define DIAG_INTERLOCK_BIT 1
`define DIAG_RATE_ZERO_BIT 2
`define DIAG_RESET_BIT     3
`define DIAG_SERVO_BIT     4
`define DIAG_JOG_MODE_BIT  5
`define DIAG_SPINDLE_BIT   6

`endif

// ### verilog/jog_motion_pkg.sv
package jog_motion_pkg;

	// motion sequencer states
	typedef enum {IDLE, RUNNING, SETTLING} motion_state_t;

	typedef logic [15:0] word_t;
	typedef logic [11:0] request_vec_t;
	typedef logic [3:0]  move_index_t;

endpackage

// ### verilog/jog_qual_if.sv
`timescale 1ns/1ns
interface jog_qual_if;

	jog_motion_pkg::request_vec_t request;   // all twelve direction requests
	jog_motion_pkg::request_vec_t rise;      // rising edges of the requests
	jog_motion_pkg::word_t        rateRawN;  // active-low rate word
	jog_motion_pkg::word_t        rateScale; // 0.01 % steps
	logic                         rateZero;  // rate reads as 0 %

	modport edge_src (input request, output rise);
	modport rate_src (input rateRawN, output rateScale, output rateZero);
	modport core (output request, input rise, output rateRawN, input rateScale,
		input rateZero);

endinterface

// ### verilog/jog_request_edges.sv
`timescale 1ns/1ns
module jog_request_edges (
	// clock and reset
	input wire logic   clk,
	input wire logic   resetn,
	// request edges
	jog_qual_if.edge_src qual
);

	jog_motion_pkg::request_vec_t previous;

	// previous request levels, set after reset so held requests need a new press
	always_ff @(posedge clk) begin
		if (!resetn) previous <= 12'hfff;
		else previous <= qual.request;
	end

	assign qual.rise = qual.request & ~previous;

endmodule // jog_request_edges

// ### verilog/jog_rate_decoder.sv
`timescale 1ns/1ns
`include "jog_motion_regs.svh"
module jog_rate_decoder (
	// clock and reset
	input wire logic   clk,
	input wire logic   resetn,
	// rate word
	jog_qual_if.rate_src qual
);

	logic rawZero;

	assign rawZero = (qual.rateRawN == `RATE_ALL_ONES) || (qual.rateRawN == `RATE_ALL_ZEROS);

	// inverted word in 0.01 percent steps
	always_ff @(posedge clk) begin
		if (!resetn) begin
			qual.rateZero  <= 1'b1;
			qual.rateScale <= 16'h0000;
		end else begin
			qual.rateZero  <= rawZero;
			qual.rateScale <= rawZero ? 16'h0000 : ~qual.rateRawN;
		end
	end

endmodule // jog_rate_decoder

// ### verilog/jog_motion_qualifier.sv
// Chosen here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ns
`include "jog_motion_regs.svh"
// Summary of operation
// - jog mode is selected only when mode bits 2,1,0 read 1,0,1
// - axes one to four take positive and negative request bits 0 to 3
// - a move starts only on a rising request edge, never on a held one
// - line and arc request pairs move two axes along a predefined path
// - one-bit diagnostic flags show each blocking condition except the index-table axis refusal while it holds
// - in-position wait holds while position error exceeds the in-position width
// - interlock setup bit 0 clear honours the global active-low lock
// - interlock setup bit 2 clear honours the per-axis active-low locks
// - interlock setup bit 3 clear honours the per-direction locks
// - global lock at 0 inhibits all motion
// - per-axis lock bits 0 to 3 at 0 inhibit that axis
// - per-direction locks are active high; milling two 4-bit inputs, turning one byte
// - turning per-direction locks apply in manual operation only
// - rate word all ones or all zeros means 0 percent, no jog
// - rate scales in 0.01 percent steps from the inverted word
// - controller reset refuses jog and raises the reset flag
// - feed setup bit 3 selects per-revolution feed, no motion with spindle stopped
// - the index-table axis refuses its own axis jog requests; line and arc moves ignore the index-table setting
// - servo indicator other than 0 blocks jog
module jog_motion_qualifier (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        resetn,
	// setup port
	input  wire logic [3:0]  regAddr,
	input  wire logic [15:0] regWriteData,
	input  wire logic        regWrite,
	input  wire logic        regRead,
	output logic      [15:0] regReadData,
	// mode and direction requests
	input  wire logic        mode_sel_b2,
	input  wire logic        mode_sel_b1,
	input  wire logic        mode_sel_b0,
	input  wire logic [3:0]  axis_pos_request,
	input  wire logic [3:0]  axis_neg_request,
	input  wire logic        line_pos_request,
	input  wire logic        line_neg_request,
	input  wire logic        arc_pos_request,
	input  wire logic        arc_neg_request,
	// interlocks
	input  wire logic        global_motion_lock_n,
	input  wire logic [3:0]  axis_motion_lock_n,
	input  wire logic [3:0]  axisDirPosLock,
	input  wire logic [3:0]  axisDirNegLock,
	input  wire logic [7:0]  turnDirLockPins,
	// rate, reset and machine state
	input  wire logic [15:0] manual_rate_scale_n,
	input  wire logic        controllerReset,
	input  wire logic [3:0]  servoIndicatorPins,
	input  wire logic        spindleTurning,
	input  wire logic [15:0] positionError,
	// motion command
	output logic             jogStart,
	output logic             jogActive,
	output logic      [3:0]  jogSelect,
	output logic      [15:0] feedScale,
	output logic             perRevFeed,
	// diagnostic flags
	output logic             inPositionWait,
	output logic             interlockActive,
	output logic             rateZero,
	output logic             resetWait,
	output logic             servoNotReady
);

	////////////////////////////////////////////////////////////////////////////////////////
	// setup registers and pin synchronisers

	jog_qual_if qual ();

	jog_motion_pkg::word_t         interlockSetup;
	jog_motion_pkg::word_t         feedSetup;
	jog_motion_pkg::word_t         inPosWidth;
	jog_motion_pkg::word_t         machineSetup;
	jog_motion_pkg::motion_state_t state;
	jog_motion_pkg::motion_state_t next_state;
	logic [7:0]                    moveCount;
	logic [7:0]                    turnLockMeta;
	logic [7:0]                    turnLockSync;
	logic [3:0]                    servoMeta;
	logic [3:0]                    servoSync;

	// register writes
	always_ff @(posedge clk) begin
		if (!resetn) begin
			interlockSetup <= `RESET_INTERLOCK_SETUP;
			feedSetup      <= `RESET_FEED_SETUP;
			inPosWidth     <= `RESET_INPOS_WIDTH;
			machineSetup   <= `RESET_MACHINE_SETUP;
		end else if (regWrite) begin
			if (regAddr == `ADDR_INTERLOCK_SETUP) interlockSetup <= regWriteData;
			if (regAddr == `ADDR_FEED_SETUP) feedSetup <= regWriteData;
			if (regAddr == `ADDR_INPOS_WIDTH) inPosWidth <= regWriteData;
			if (regAddr == `ADDR_MACHINE_SETUP) machineSetup <= regWriteData;
		end
	end

	// two-stage synchronisers for the turning lock byte and servo indicator pins
	always_ff @(posedge clk) begin
		if (!resetn) begin
			turnLockMeta <= 8'h00;
			turnLockSync <= 8'h00;
			servoMeta    <= 4'hf;
			servoSync    <= 4'hf;
		end else begin
			turnLockMeta <= turnDirLockPins;
			turnLockSync <= turnLockMeta;
			servoMeta    <= servoIndicatorPins;
			servoSync    <= servoMeta;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////
	// request edges and rate decoding

	jog_request_edges edges (
		.clk    (clk),
		.resetn (resetn),
		.qual   (qual.edge_src)
	);

	jog_rate_decoder rate (
		.clk    (clk),
		.resetn (resetn),
		.qual   (qual.rate_src)
	);

	// axis requests; line and arc pairs
	assign qual.request = {arc_neg_request, arc_pos_request, line_neg_request,
		line_pos_request, axis_neg_request, axis_pos_request};
	assign qual.rateRawN = manual_rate_scale_n;

	////////////////////////////////////////////////////////////////////////////////////////
	// qualification

	logic [2:0] modeCode;
	logic       jogMode;
	logic       manualMode;
	logic       turning;
	logic       globalLock;
	logic [3:0] axisLock;
	logic [3:0] dirPosLock;
	logic [3:0] dirNegLock;
	logic [3:0] turnPos;
	logic [3:0] turnNeg;
	logic [3:0] indexMask;
	logic       pathLock;
	logic [11:0] blockVec;
	logic       servoReady;
	logic       spindleHold;
	logic       commonOk;
	logic       inPosNow;
	logic       anyLock;
	logic [11:0] candidates;
	logic       pickValid;
	logic [3:0] pickIndex;
	logic       keepRunning;

	// lowest numbered candidate wins
	function automatic logic [4:0] pick_first(input logic [11:0] vec);
		logic [4:0] found;
		found = 5'h00;
		for (int i = 11; i >= 0; i--) begin
			if (vec[i]) found = {1'b1, 4'(i)};
		end
		return found;
	endfunction

	// move index decoded back to its request bit
	function automatic logic bit_at(input logic [11:0] vec, input logic [3:0] idx);
		return (idx < 4'hc) ? vec[idx] : 1'b0;
	endfunction

	assign modeCode   = {mode_sel_b2, mode_sel_b1, mode_sel_b0};
	assign jogMode    = (modeCode == `MODE_JOG);
	assign manualMode = jogMode || (modeCode == `MODE_HANDLE);
	assign turning    = machineSetup[`TURNING_VARIANT_BIT];

	assign globalLock = !interlockSetup[`GLOBAL_LOCK_DISABLE_BIT] && !global_motion_lock_n;

	assign axisLock = interlockSetup[`AXIS_LOCK_DISABLE_BIT] ? 4'h0 : ~axis_motion_lock_n;

	assign turnPos = manualMode ?
		{2'b00, turnLockSync[`TURN_POS_LOCK2], turnLockSync[`TURN_POS_LOCK1]} : 4'h0;
	assign turnNeg = manualMode ?
		{2'b00, turnLockSync[`TURN_NEG_LOCK2], turnLockSync[`TURN_NEG_LOCK1]} : 4'h0;

	assign dirPosLock = interlockSetup[`DIR_LOCK_DISABLE_BIT] ? 4'h0 :
		(turning ? turnPos : axisDirPosLock);
	assign dirNegLock = interlockSetup[`DIR_LOCK_DISABLE_BIT] ? 4'h0 :
		(turning ? turnNeg : axisDirNegLock);

	assign indexMask = machineSetup[`INDEX_AXIS_ENABLE_BIT] ?
		4'(4'h1 << machineSetup[`INDEX_AXIS_MSB:`INDEX_AXIS_LSB]) : 4'h0;

	// path moves run on the first two axes
	assign pathLock = axisLock[0] || axisLock[1];
	assign blockVec = {{4{pathLock}}, axisLock | dirNegLock | indexMask,
		axisLock | dirPosLock | indexMask};

	assign servoReady = (servoSync == `SERVO_READY_CODE);

	// per-revolution feed needs a turning spindle
	assign spindleHold = feedSetup[`PER_REV_FEED_SEL_BIT] && !spindleTurning;

	assign inPosNow = (positionError > inPosWidth);

	assign commonOk = jogMode && !globalLock && !qual.rateZero && !controllerReset &&
		servoReady && !spindleHold;

	assign anyLock = globalLock || (|axisLock) || (|dirPosLock) || (|dirNegLock);

	// only fresh edges of unblocked requests
	assign candidates = qual.rise & ~blockVec;
	assign {pickValid, pickIndex} = pick_first(candidates);

	// a running move continues while its request stays and nothing blocks it
	assign keepRunning = commonOk && bit_at(qual.request, jogSelect) &&
		!bit_at(blockVec, jogSelect);

	////////////////////////////////////////////////////////////////////////////////////////
	// motion sequencer

	// next state
	always_comb begin
		next_state = state;
		unique case (state)
			jog_motion_pkg::IDLE: begin
				if (commonOk && pickValid) next_state = jog_motion_pkg::RUNNING;
			end
			jog_motion_pkg::RUNNING: begin
				if (!keepRunning) next_state = jog_motion_pkg::SETTLING;
			end
			jog_motion_pkg::SETTLING: begin
				if (!inPosNow) next_state = jog_motion_pkg::IDLE;
			end
		endcase
	end

	// state register
	always_ff @(posedge clk) begin
		if (!resetn) state <= jog_motion_pkg::IDLE;
		else state <= next_state;
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			jogStart  <= 1'b0;
			jogActive <= 1'b0;
			jogSelect <= 4'h0;
			moveCount <= 8'h00;
		end else begin
			jogStart  <= (state == jog_motion_pkg::IDLE) && commonOk && pickValid;
			jogActive <= (next_state == jog_motion_pkg::RUNNING);
			if ((state == jog_motion_pkg::IDLE) && commonOk && pickValid) begin
				jogSelect <= pickIndex;
				moveCount <= moveCount + 8'h01;
			end
		end
	end

	// feed scale and feed type
	always_ff @(posedge clk) begin
		if (!resetn) begin
			feedScale  <= 16'h0000;
			perRevFeed <= 1'b0;
		end else begin
			feedScale  <= qual.rateScale;
			perRevFeed <= feedSetup[`PER_REV_FEED_SEL_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////
	// diagnostic flags

	always_ff @(posedge clk) begin
		if (!resetn) begin
			inPositionWait  <= 1'b0;
			interlockActive <= 1'b0;
			rateZero        <= 1'b1;
			resetWait       <= 1'b1;
			servoNotReady   <= 1'b1;
		end else begin
			inPositionWait  <= inPosNow;
			interlockActive <= anyLock;
			rateZero        <= qual.rateZero;
			resetWait       <= controllerReset;
			servoNotReady   <= !servoReady;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////
	// register reads

	jog_motion_pkg::word_t diagWord;
	jog_motion_pkg::word_t moveWord;
	jog_motion_pkg::word_t readValue;

	// live diagnostic word
	always_comb begin
		diagWord                       = 16'h0000;
		diagWord[`DIAG_INPOS_BIT]      = inPositionWait;
		diagWord[`DIAG_INTERLOCK_BIT]  = interlockActive;
		diagWord[`DIAG_RATE_ZERO_BIT]  = rateZero;
		diagWord[`DIAG_RESET_BIT]      = resetWait;
		diagWord[`DIAG_SERVO_BIT]      = servoNotReady;
		diagWord[`DIAG_JOG_MODE_BIT]   = jogMode;
		diagWord[`DIAG_SPINDLE_BIT]    = spindleHold;
	end

	// move word: count, running flag, selected move
	assign moveWord = {moveCount, 3'b000, jogActive, jogSelect};

	// read decode, unmapped addresses read zero
	assign readValue =
		(regAddr == `ADDR_INTERLOCK_SETUP) ? interlockSetup :
		(regAddr == `ADDR_FEED_SETUP)      ? feedSetup :
		(regAddr == `ADDR_INPOS_WIDTH)     ? inPosWidth :
		(regAddr == `ADDR_MACHINE_SETUP)   ? machineSetup :
		(regAddr == `ADDR_DIAG_STATUS)     ? diagWord :
		(regAddr == `ADDR_MOVE_STATUS)     ? moveWord : 16'h0000;

	// read data stand only in the cycle after the strobe
	always_ff @(posedge clk) begin
		if (!resetn) regReadData <= 16'h0000;
		else regReadData <= regRead ? readValue : 16'h0000;
	end

endmodule // jog_motion_qualifier

// ### testbench/jog_qualifier_monitor.sv
`timescale 1ns/1ns
`include "jog_motion_regs.svh"
module jog_qualifier_monitor (
	// clock and reset
	input wire logic        clk,
	input wire logic        resetn,
	// setup port
	input wire logic [3:0]  regAddr,
	input wire logic [15:0] regWriteData,
	input wire logic        regWrite,
	// requests and inputs
	input wire logic        mode_sel_b2,
	input wire logic        mode_sel_b1,
	input wire logic        mode_sel_b0,
	input wire logic [3:0]  axis_pos_request,
	input wire logic [3:0]  axis_neg_request,
	input wire logic        line_pos_request,
	input wire logic        line_neg_request,
	input wire logic        arc_pos_request,
	input wire logic        arc_neg_request,
	input wire logic        global_motion_lock_n,
	input wire logic [3:0]  axis_motion_lock_n,
	input wire logic [15:0] manual_rate_scale_n,
	input wire logic        controllerReset,
	input wire logic [15:0] positionError,
	// outputs
	input wire logic        jogStart,
	input wire logic [3:0]  jogSelect,
	input wire logic [15:0] feedScale,
	input wire logic        inPositionWait,
	input wire logic        interlockActive,
	input wire logic        rateZero,
	input wire logic        resetWait
);
	logic [11:0] reqVec;
	logic [11:0] prevReq;
	logic [11:0] prev2Req;
	logic [3:0]  prevLockN;
	logic [3:0]  lockCfg;
	logic [15:0] inposWidth;

	// requests in move index order
	assign reqVec = {arc_neg_request, arc_pos_request, line_neg_request, line_pos_request,
		axis_neg_request, axis_pos_request};

	// request history for edge checks
	always_ff @(posedge clk) begin
		prevReq <= reqVec;
		prev2Req <= prevReq;
		prevLockN <= axis_motion_lock_n;
	end

	// shadow of the setup words
	always_ff @(posedge clk) begin
		if (!resetn) begin
			lockCfg <= 4'h0;
			inposWidth <= `RESET_INPOS_WIDTH;
		end else if (regWrite && regAddr == `ADDR_INTERLOCK_SETUP) begin
			lockCfg <= regWriteData[3:0];
		end else if (regWrite && regAddr == `ADDR_INPOS_WIDTH) begin
			inposWidth <= regWriteData;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	////////////////////////////////////////////////////////////////////////////////
	chk_start_mode: assert property (jogStart |->
		$past({mode_sel_b2, mode_sel_b1, mode_sel_b0}) == `MODE_JOG) else $error("start off jog");
	chk_start_edge: assert property (jogStart |->
		prevReq[jogSelect] && !prev2Req[jogSelect]) else $error("start without rise");
	chk_reset_block: assert property (jogStart |-> !$past(controllerReset))
		else $error("start in reset");
	chk_reset_flag: assert property ($past(resetn) |->
		resetWait == $past(controllerReset)) else $error("reset flag wrong");
	chk_global_lock: assert property (jogStart |->
		$past(global_motion_lock_n) || $past(lockCfg[0])) else $error("start under lock");
	chk_axis_lock: assert property (jogStart && jogSelect < 4'h8 |->
		prevLockN[jogSelect[1:0]] || $past(lockCfg[2])) else $error("start under axis lock");
	chk_lock_flag: assert property ($past(resetn) && !$past(global_motion_lock_n)
		&& !$past(lockCfg[0]) |-> interlockActive) else $error("lock flag low");
	chk_rate_zero: assert property ($past(resetn) && $past(resetn, 2) |->
		rateZero == ($past(manual_rate_scale_n, 2) inside {`RATE_ALL_ONES, `RATE_ALL_ZEROS}))
		else $error("rate zero wrong");
	chk_rate_scale: assert property ($past(resetn) && $past(resetn, 2) && !rateZero |->
		feedScale == ~$past(manual_rate_scale_n, 2)) else $error("rate scale wrong");
	chk_inpos_wait: assert property ($past(resetn) |->
		inPositionWait == ($past(positionError) > $past(inposWidth))) else $error("inpos wrong");
endmodule // jog_qualifier_monitor

bind jog_motion_qualifier jog_qualifier_monitor jog_qualifier_monitor_i (.*);

// ### testbench/jog_ladder_model.sv
`timescale 1ns/1ns
module jog_ladder_model #(
	parameter int SERVO_LOOP_GAIN = 3000
) (
	// commands from the bench
	input wire logic [2:0]  modeCode,
	input wire logic [11:0] pressVec,
	// interface pins
	output logic            mode_sel_b2,
	output logic            mode_sel_b1,
	output logic            mode_sel_b0,
	output logic [3:0]      axis_pos_request,
	output logic [3:0]      axis_neg_request,
	output logic            line_pos_request,
	output logic            line_neg_request,
	output logic            arc_pos_request,
	output logic            arc_neg_request
);
	assign {mode_sel_b2, mode_sel_b1, mode_sel_b0} = modeCode;
	assign axis_pos_request = pressVec[3:0];
	assign axis_neg_request = pressVec[7:4];
	assign {arc_neg_request, arc_pos_request, line_neg_request, line_pos_request} = pressVec[11:8];
endmodule // jog_ladder_model

// ### testbench/test_jog_motion_qualifier.sv
`timescale 1ns/1ns
`include "jog_motion_regs.svh"
module test_jog_motion_qualifier;
	logic        clk, resetn, regWrite, regRead, controllerReset, spindleTurning;
	logic [3:0]  regAddr, axis_motion_lock_n, axisDirPosLock, axisDirNegLock;
	logic [15:0] regWriteData, regReadData, manual_rate_scale_n, positionError, feedScale;
	logic        mode_sel_b2, mode_sel_b1, mode_sel_b0, global_motion_lock_n;
	logic [3:0]  axis_pos_request, axis_neg_request, servoIndicatorPins, jogSelect;
	logic        line_pos_request, line_neg_request, arc_pos_request, arc_neg_request;
	logic        jogStart, jogActive, perRevFeed, inPositionWait, interlockActive;
	logic        rateZero, resetWait, servoNotReady;
	logic [7:0]  turnDirLockPins;
	logic [2:0]  modeCode;
	logic [11:0] pressVec;
	int          err_total, check_count;

	jog_motion_qualifier jog_motion_qualifier_i (.*);
	jog_ladder_model jog_ladder_model_i (.*);

	// clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp)
			err_total++;
		if (seen !== exp)
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
	endtask

	task automatic regWr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		regWrite <= 1'b1;
		regAddr <= a;
		regWriteData <= d;
		@(posedge clk);
		regWrite <= 1'b0;
	endtask

	task automatic regChk(input logic [3:0] a, input logic [15:0] exp);
		@(posedge clk);
		regRead <= 1'b1;
		regAddr <= a;
		@(posedge clk);
		regRead <= 1'b0;
		#1 check(regReadData, exp);
	endtask

	task automatic settle;
		repeat (5) @(posedge clk);
		#1;
	endtask

	// press one request, look for a start, release
	task automatic tryMove(input int idx, input logic expStart);
		logic seen;
		seen = 1'b0;
		settle;
		@(posedge clk);
		pressVec <= 12'h001 << idx;
		for (int i = 0; i < 6 && !seen; i++) begin
			@(posedge clk);
			#1 seen = (jogStart === 1'b1);
		end
		check({15'h0000, seen}, {15'h0000, expStart});
		if (seen) begin
			check({12'h000, jogSelect}, 16'(idx));
			check({15'h0000, jogActive}, 16'h0001);
		end
		@(posedge clk);
		pressVec <= 12'h000;
		if (expStart && !seen)
			give_verdict;
	endtask

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{err_total, check_count} = 0;
		{regWrite, regRead, regAddr, regWriteData, controllerReset, pressVec} = '0;
		{axisDirPosLock, axisDirNegLock, turnDirLockPins, servoIndicatorPins} = '0;
		{resetn, positionError} = '0;
		{spindleTurning, global_motion_lock_n, axis_motion_lock_n} = 6'h3f;
		manual_rate_scale_n = 16'hd8ef;
		modeCode = `MODE_JOG;
		repeat (8) @(posedge clk);
		resetn <= 1'b1;
		regChk(`ADDR_INTERLOCK_SETUP, 16'h0000);
		regChk(`ADDR_INPOS_WIDTH, 16'h0014);
		regChk(`ADDR_MACHINE_SETUP, 16'h0000);
		regChk(4'hf, 16'h0000);
		settle;
		check(feedScale, `RATE_FULL_SCALE);
		$display("end of reset test");
		for (int k = 0; k < 12; k++) tryMove(k, 1'b1);
		for (int m = 0; m < 8; m++) begin
			modeCode <= m[2:0];
			tryMove(0, m == 5);
		end
		settle;
		pressVec <= 12'h001;
		settle;
		modeCode <= `MODE_JOG;
		settle;
		check({15'h0000, jogActive}, 16'h0000);
		pressVec <= 12'h000;
		tryMove(0, 1'b1);
		$display("end of request test");
		global_motion_lock_n <= 1'b0;
		axis_motion_lock_n <= 4'hd;
		axisDirPosLock <= 4'h4;
		settle;
		check({15'h0000, interlockActive}, 16'h0001);
		tryMove(0, 1'b0);
		regWr(`ADDR_INTERLOCK_SETUP, 16'h0001);
		tryMove(0, 1'b1);
		tryMove(5, 1'b0);
		regWr(`ADDR_INTERLOCK_SETUP, 16'h0005);
		tryMove(1, 1'b1);
		tryMove(2, 1'b0);
		tryMove(6, 1'b1);
		regWr(`ADDR_INTERLOCK_SETUP, 16'h000d);
		tryMove(2, 1'b1);
		regChk(`ADDR_INTERLOCK_SETUP, 16'h000d);
		$display("end of lock test");
		manual_rate_scale_n <= `RATE_ALL_ONES;
		tryMove(0, 1'b0);
		check({15'h0000, rateZero}, 16'h0001);
		manual_rate_scale_n <= `RATE_ALL_ZEROS;
		tryMove(0, 1'b0);
		manual_rate_scale_n <= 16'h0001;
		settle;
		check(feedScale, 16'hfffe);
		controllerReset <= 1'b1;
		servoIndicatorPins <= 4'h3;
		tryMove(0, 1'b0);
		check({15'h0000, resetWait}, 16'h0001);
		check({15'h0000, servoNotReady}, 16'h0001);
		controllerReset <= 1'b0;
		tryMove(0, 1'b0);
		servoIndicatorPins <= 4'h0;
		regWr(`ADDR_FEED_SETUP, 16'h0008);
		spindleTurning <= 1'b0;
		tryMove(0, 1'b0);
		check({15'h0000, perRevFeed}, 16'h0001);
		spindleTurning <= 1'b1;
		tryMove(0, 1'b1);
		regWr(`ADDR_MACHINE_SETUP, 16'h0005);
		regChk(`ADDR_MACHINE_SETUP, 16'h0005);
		tryMove(1, 1'b0);
		tryMove(0, 1'b1);
		// turning variant: lock byte pins only, milling locks ignored
		regWr(`ADDR_MACHINE_SETUP, 16'h0008);
		regWr(`ADDR_INTERLOCK_SETUP, 16'h0005);
		turnDirLockPins <= 8'h04;
		tryMove(0, 1'b0);
		tryMove(2, 1'b1);
		settle;
		check({15'h0000, interlockActive}, 16'h0001);
		modeCode <= 3'h1;
		settle;
		check({15'h0000, interlockActive}, 16'h0000);
		modeCode <= `MODE_JOG;
		turnDirLockPins <= 8'h00;
		$display("end of machine test");
		positionError <= 16'h0015;
		settle;
		check({15'h0000, inPositionWait}, 16'h0001);
		positionError <= 16'h0014;
		settle;
		check({15'h0000, inPositionWait}, 16'h0000);
		regChk(`ADDR_DIAG_STATUS, 16'h0001 << `DIAG_JOG_MODE_BIT);
		regChk(`ADDR_MOVE_STATUS, 16'h1502);
		$display("end of position test");
		give_verdict;
	end
endmodule // test_jog_motion_qualifier
